// ===== src/int_exec_pkg.sv
package int_exec_pkg;
  // Datapath widths
  localparam int DATA_W = 64;
  localparam int WORD_W = 32;
  localparam int SHAMT_W = 5;
  localparam int IMM_W = 16;
  // Memory-management command strobe positions
  localparam int TLB_CMD_W = 4;
  localparam int TLB_WRITE_IDX_BIT = 0;
  localparam int TLB_WRITE_RND_BIT = 1;
  localparam int TLB_PROBE_BIT = 2;
  localparam int TLB_READ_IDX_BIT = 3;
  // Reset values
  localparam logic [63:0] RESULT_RST = 64'h0000_0000_0000_0000;
  localparam logic [3:0] TLB_CMD_RST = 4'h0;

  // Decoded operations
  typedef enum logic [5:0] {
    OP_SHIFT_LEFT, OP_SHIFT_LEFT_VAR, OP_SHIFT_RZERO, OP_SHIFT_RZERO_VAR,
    OP_SHIFT_RSIGN, OP_SHIFT_RSIGN_VAR, OP_LESS_SET, OP_LESS_SET_IMM,
    OP_LESS_SET_U, OP_LESS_SET_IMM_U, OP_XOR_REG, OP_XOR_IMM,
    OP_TRAP_EQ, OP_TRAP_EQ_IMM, OP_TRAP_NE, OP_TRAP_NE_IMM,
    OP_TRAP_GE, OP_TRAP_GE_IMM, OP_TRAP_GE_U, OP_TRAP_GE_IMM_U,
    OP_TRAP_LT, OP_TRAP_LT_IMM, OP_TRAP_LT_U, OP_TRAP_LT_IMM_U,
    OP_COP2_DSTORE, OP_COP2_WSTORE, OP_TLB_WRITE_IDX, OP_TLB_WRITE_RND,
    OP_TLB_PROBE, OP_TLB_READ_IDX, OP_ISSUE_ALONE_NOP, OP_SYSTEM_CALL,
    OP_WAIT_IRQ, OP_SUBTRACT, OP_SUBTRACT_NO_OVF
  } op_type;

  // Wait sequencer states
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_STALL = 2'b10
  } wait_state_type;
endpackage

// ===== src/int_exec_unit.sv
`timescale 1ns/10ps
// Operation
// - Left shift fills zeros, amount field or A[4:0]
// - Logical right shift treats value unsigned
// - Arithmetic right shift keeps value signed
// - Signed less-than writes one else zero
// - Unsigned less-than, register or immediate
// - Exclusive-OR immediate is zero-extended
// - Equal and not-equal traps
// - Signed greater-equal and less-than traps
// - Unsigned greater-equal and less-than traps
// - Wait stalls until an interrupt
// - Coprocessor stores to A plus offset
// - Four memory-management commands dispatched
// - Issue-alone nop blocks paired issue
module int_exec_unit #(
  parameter int DATA_W = int_exec_pkg::DATA_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Issue
  input wire logic issue_valid,
  input wire int_exec_pkg::op_type op,
  input wire logic [DATA_W-1:0] source_reg_a,
  input wire logic [DATA_W-1:0] source_reg_b,
  input wire logic [int_exec_pkg::IMM_W-1:0] imm,
  input wire logic [int_exec_pkg::SHAMT_W-1:0] shift_amount_field,
  input wire logic [DATA_W-1:0] coproc_reg,
  input wire logic irq_pending,
  // Writeback and exceptions
  output logic result_valid_q,
  output logic [DATA_W-1:0] result_q,
  output logic trap_q,
  output logic system_call_op_q,
  output logic overflow_q,
  // Store port
  output logic store_valid_q,
  output logic store_dword_q,
  output logic [DATA_W-1:0] store_addr_q,
  output logic [DATA_W-1:0] store_data_q,
  // Memory-management and issue control
  output logic [int_exec_pkg::TLB_CMD_W-1:0] tlb_cmd_q,
  output logic issue_alone_q,
  output logic stall_q
);
  localparam int W = int_exec_pkg::WORD_W;

  int_exec_pkg::wait_state_type state_q;
  logic accept;
  logic [DATA_W-1:0] imm_sext, imm_zext, opnd2, res_d;
  logic [W-1:0] word_b, sub_word;
  logic [int_exec_pkg::SHAMT_W-1:0] amt;
  logic eq, lt_s, lt_u, wb_d, trap_d, ovf_d;

  function automatic logic [DATA_W-1:0] sext_word(input logic [W-1:0] v);
    sext_word = {{(DATA_W-W){v[W-1]}}, v};
  endfunction

  // Operand shaping
  assign accept = issue_valid && (state_q == int_exec_pkg::ST_RUN);
  assign imm_sext = {{(DATA_W-int_exec_pkg::IMM_W){imm[15]}}, imm};
  assign imm_zext = {{(DATA_W-int_exec_pkg::IMM_W){1'b0}}, imm};
  assign word_b = source_reg_b[W-1:0];
  assign sub_word = source_reg_a[W-1:0] - word_b;

  // Immediate forms compare against the sign-extended immediate
  always_comb begin
    case (op)
      int_exec_pkg::OP_LESS_SET_IMM, int_exec_pkg::OP_LESS_SET_IMM_U,
      int_exec_pkg::OP_TRAP_EQ_IMM, int_exec_pkg::OP_TRAP_NE_IMM,
      int_exec_pkg::OP_TRAP_GE_IMM, int_exec_pkg::OP_TRAP_GE_IMM_U,
      int_exec_pkg::OP_TRAP_LT_IMM, int_exec_pkg::OP_TRAP_LT_IMM_U: begin
        opnd2 = imm_sext;
      end
      default: begin
        opnd2 = source_reg_b;
      end
    endcase
  end

  // Shared comparators
  assign eq = source_reg_a == opnd2;
  assign lt_s = $signed(source_reg_a) < $signed(opnd2);
  assign lt_u = source_reg_a < opnd2;

  // Fixed amount from the instruction, variable from A[4:0]
  always_comb begin
    case (op)
      int_exec_pkg::OP_SHIFT_LEFT_VAR, int_exec_pkg::OP_SHIFT_RZERO_VAR,
      int_exec_pkg::OP_SHIFT_RSIGN_VAR: begin
        amt = source_reg_a[int_exec_pkg::SHAMT_W-1:0];
      end
      default: begin
        amt = shift_amount_field;
      end
    endcase
  end

  // Result, writeback and exception decode
  always_comb begin
    res_d = int_exec_pkg::RESULT_RST;
    wb_d = 1'b0;
    trap_d = 1'b0;
    ovf_d = 1'b0;
    case (op)
      int_exec_pkg::OP_SHIFT_LEFT, int_exec_pkg::OP_SHIFT_LEFT_VAR: begin
        res_d = sext_word(word_b << amt);
        wb_d = 1'b1;
      end
      int_exec_pkg::OP_SHIFT_RZERO, int_exec_pkg::OP_SHIFT_RZERO_VAR: begin
        res_d = sext_word(word_b >> amt);
        wb_d = 1'b1;
      end
      int_exec_pkg::OP_SHIFT_RSIGN, int_exec_pkg::OP_SHIFT_RSIGN_VAR: begin
        res_d = sext_word(W'($signed(word_b) >>> amt));
        wb_d = 1'b1;
      end
      int_exec_pkg::OP_LESS_SET, int_exec_pkg::OP_LESS_SET_IMM: begin
        res_d = {{(DATA_W-1){1'b0}}, lt_s};
        wb_d = 1'b1;
      end
      int_exec_pkg::OP_LESS_SET_U, int_exec_pkg::OP_LESS_SET_IMM_U: begin
        res_d = {{(DATA_W-1){1'b0}}, lt_u};
        wb_d = 1'b1;
      end
      int_exec_pkg::OP_XOR_REG: begin
        res_d = source_reg_a ^ source_reg_b;
        wb_d = 1'b1;
      end
      int_exec_pkg::OP_XOR_IMM: begin
        res_d = source_reg_a ^ imm_zext;
        wb_d = 1'b1;
      end
      int_exec_pkg::OP_TRAP_EQ, int_exec_pkg::OP_TRAP_EQ_IMM: begin
        trap_d = eq;
      end
      int_exec_pkg::OP_TRAP_NE, int_exec_pkg::OP_TRAP_NE_IMM: begin
        trap_d = !eq;
      end
      int_exec_pkg::OP_TRAP_GE, int_exec_pkg::OP_TRAP_GE_IMM: begin
        trap_d = !lt_s;
      end
      int_exec_pkg::OP_TRAP_LT, int_exec_pkg::OP_TRAP_LT_IMM: begin
        trap_d = lt_s;
      end
      int_exec_pkg::OP_TRAP_GE_U, int_exec_pkg::OP_TRAP_GE_IMM_U: begin
        trap_d = !lt_u;
      end
      int_exec_pkg::OP_TRAP_LT_U, int_exec_pkg::OP_TRAP_LT_IMM_U: begin
        trap_d = lt_u;
      end
      int_exec_pkg::OP_SUBTRACT: begin
        res_d = sext_word(sub_word);
        ovf_d = (source_reg_a[W-1] != word_b[W-1]) &&
                (sub_word[W-1] != source_reg_a[W-1]);
        wb_d = !ovf_d;
      end
      int_exec_pkg::OP_SUBTRACT_NO_OVF: begin
        res_d = sext_word(sub_word);
        wb_d = 1'b1;
      end
      default: begin
        res_d = int_exec_pkg::RESULT_RST;
      end
    endcase
  end

  // Writeback and exception registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      result_valid_q <= 1'b0;
      result_q <= int_exec_pkg::RESULT_RST;
      trap_q <= 1'b0;
      overflow_q <= 1'b0;
      system_call_op_q <= 1'b0;
    end else begin
      result_valid_q <= accept && wb_d;
      result_q <= accept && wb_d ? res_d : result_q;
      trap_q <= accept && trap_d;
      overflow_q <= accept && ovf_d;
      system_call_op_q <= accept && op == int_exec_pkg::OP_SYSTEM_CALL;
    end
  end

  // Coprocessor store port
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      store_valid_q <= 1'b0;
      store_dword_q <= 1'b0;
      store_addr_q <= int_exec_pkg::RESULT_RST;
      store_data_q <= int_exec_pkg::RESULT_RST;
    end else if (accept && (op == int_exec_pkg::OP_COP2_DSTORE ||
                            op == int_exec_pkg::OP_COP2_WSTORE)) begin
      store_valid_q <= 1'b1;
      store_dword_q <= op == int_exec_pkg::OP_COP2_DSTORE;
      store_addr_q <= source_reg_a + imm_sext;
      store_data_q <= op == int_exec_pkg::OP_COP2_DSTORE ? coproc_reg :
                      {{(DATA_W-W){1'b0}}, coproc_reg[W-1:0]};
    end else begin
      store_valid_q <= 1'b0;
    end
  end

  // Memory-management dispatch and paired-issue inhibit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tlb_cmd_q <= int_exec_pkg::TLB_CMD_RST;
      issue_alone_q <= 1'b0;
    end else begin
      tlb_cmd_q <= int_exec_pkg::TLB_CMD_RST;
      if (accept) begin
        tlb_cmd_q[int_exec_pkg::TLB_WRITE_IDX_BIT] <=
          op == int_exec_pkg::OP_TLB_WRITE_IDX;
        tlb_cmd_q[int_exec_pkg::TLB_WRITE_RND_BIT] <=
          op == int_exec_pkg::OP_TLB_WRITE_RND;
        tlb_cmd_q[int_exec_pkg::TLB_PROBE_BIT] <=
          op == int_exec_pkg::OP_TLB_PROBE;
        tlb_cmd_q[int_exec_pkg::TLB_READ_IDX_BIT] <=
          op == int_exec_pkg::OP_TLB_READ_IDX;
      end
      issue_alone_q <= accept &&
                       op == int_exec_pkg::OP_ISSUE_ALONE_NOP;
    end
  end

  // Wait sequencer: stall until an interrupt is pending
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= int_exec_pkg::ST_RUN;
      stall_q <= 1'b0;
    end else begin
      case (state_q)
        int_exec_pkg::ST_RUN: begin
          if (accept && op == int_exec_pkg::OP_WAIT_IRQ && !irq_pending) begin
            state_q <= int_exec_pkg::ST_STALL;
            stall_q <= 1'b1;
          end
        end
        int_exec_pkg::ST_STALL: begin
          if (irq_pending) begin
            state_q <= int_exec_pkg::ST_RUN;
            stall_q <= 1'b0;
          end
        end
        default: begin
          state_q <= int_exec_pkg::ST_RUN;
          stall_q <= 1'b0;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_wait_taken;
    accept && op == int_exec_pkg::OP_WAIT_IRQ && !irq_pending;
  endsequence
  sequence s_stalled_quiet;
    stall_q && !result_valid_q && !store_valid_q;
  endsequence

  AST_SHL_VAR: assert property (
    accept && op == int_exec_pkg::OP_SHIFT_LEFT_VAR |=>
      result_valid_q && result_q[W-1:0] ==
      ($past(source_reg_b[W-1:0]) << $past(source_reg_a[4:0])))
    else $error("variable left shift result wrong");
  AST_SHR_ZERO: assert property (
    accept && op == int_exec_pkg::OP_SHIFT_RZERO && shift_amount_field != 0
      |=> result_q[W-1] == 1'b0)
    else $error("logical right shift did not zero fill");
  AST_SHR_SIGN: assert property (
    accept && op == int_exec_pkg::OP_SHIFT_RSIGN_VAR && source_reg_b[W-1]
      |=> result_q[W-1] && result_q[DATA_W-1])
    else $error("arithmetic right shift lost sign");
  AST_LESS_SIGNED: assert property (
    accept && op == int_exec_pkg::OP_LESS_SET |=> result_q ==
      DATA_W'($signed($past(source_reg_a)) < $signed($past(source_reg_b))))
    else $error("signed set-less-than result wrong");
  AST_LESS_UNSIGNED: assert property (
    accept && op == int_exec_pkg::OP_LESS_SET_U |=> result_valid_q &&
      result_q == DATA_W'($past(source_reg_a) < $past(source_reg_b)))
    else $error("unsigned set-less-than result wrong");
  AST_XOR_IMM: assert property (
    accept && op == int_exec_pkg::OP_XOR_IMM |=> result_q[DATA_W-1:16] ==
      $past(source_reg_a[DATA_W-1:16]))
    else $error("xor immediate not zero extended");
  AST_TRAP_EQ: assert property (
    accept && op == int_exec_pkg::OP_TRAP_EQ |=>
      trap_q == ($past(source_reg_a) == $past(source_reg_b)) &&
      !result_valid_q)
    else $error("equal trap wrong");
  AST_TRAP_GE: assert property (
    accept && op == int_exec_pkg::OP_TRAP_GE_IMM |=>
      trap_q == ($signed($past(source_reg_a)) >= $signed($past(imm_sext))))
    else $error("signed trap wrong");
  AST_TRAP_LTU: assert property (
    accept && op == int_exec_pkg::OP_TRAP_LT_U |=>
      trap_q == ($past(source_reg_a) < $past(source_reg_b)))
    else $error("unsigned trap wrong");
  AST_WAIT_STALL: assert property (
    s_wait_taken ##1 !irq_pending |=> s_stalled_quiet)
    else $error("wait did not hold stall");
  AST_WAIT_WAKE: assert property (
    stall_q && irq_pending |=> !stall_q && state_q == int_exec_pkg::ST_RUN)
    else $error("stall not released by interrupt");
  AST_STORE_ADDR: assert property (
    accept && op == int_exec_pkg::OP_COP2_WSTORE |=> store_valid_q &&
      !store_dword_q && store_addr_q == $past(source_reg_a + imm_sext))
    else $error("coprocessor store address wrong");
  AST_TLB_PROBE: assert property (
    accept && op == int_exec_pkg::OP_TLB_PROBE |=>
      tlb_cmd_q == 4'h4 ##1 tlb_cmd_q == 4'h0 || $past(accept))
    else $error("probe command not dispatched once");
  AST_ALONE: assert property (
    accept && op == int_exec_pkg::OP_ISSUE_ALONE_NOP |=>
      issue_alone_q && !result_valid_q && !trap_q)
    else $error("issue-alone nop misbehaved");
  AST_SYSTEM_CALL_OP: assert property (
    accept && op == int_exec_pkg::OP_SYSTEM_CALL |=>
      system_call_op_q && !result_valid_q)
    else $error("system call not raised");
  AST_SUB_OVF: assert property (
    overflow_q |-> !result_valid_q &&
      $past(op) == int_exec_pkg::OP_SUBTRACT)
    else $error("overflow from wrong operation");
endmodule

// ===== tb/test_integer_shift_compare_trap_ops.sv
`timescale 1ns/10ps
module test_integer_shift_compare_trap_ops;
  typedef struct {
    int_exec_pkg::op_type op;
    logic [63:0] a;
    logic [63:0] b;
    logic [15:0] im;
    logic [4:0] sh;
    logic trap;
    logic [63:0] exp;
  } row_type;
  localparam logic [63:0] M = 64'hFFFFFFFFFFFFFFFF;
  localparam logic [63:0] Z = 64'h0;
  localparam int ROWS = 27;
  // Stimulus
  logic clk;
  logic sys_rst;
  logic issue_valid;
  int_exec_pkg::op_type op;
  logic [63:0] source_reg_a;
  logic [63:0] source_reg_b;
  logic [15:0] imm;
  logic [4:0] shift_amount_field;
  logic [63:0] coproc_reg;
  logic irq_pending;
  // Observed outputs
  logic result_valid_q;
  logic [63:0] result_q;
  logic trap_q;
  logic system_call_op_q;
  logic overflow_q;
  logic store_valid_q;
  logic store_dword_q;
  logic [63:0] store_addr_q;
  logic [63:0] store_data_q;
  logic [3:0] tlb_cmd_q;
  logic issue_alone_q;
  logic stall_q;
  int bad_count = 0;
  int check_count = 0;
  row_type rows [ROWS];

  int_exec_unit dut_u (
    .clk(clk), .sys_rst(sys_rst), .issue_valid(issue_valid), .op(op),
    .source_reg_a(source_reg_a), .source_reg_b(source_reg_b), .imm(imm),
    .shift_amount_field(shift_amount_field), .coproc_reg(coproc_reg),
    .irq_pending(irq_pending), .result_valid_q(result_valid_q),
    .result_q(result_q), .trap_q(trap_q), .system_call_op_q(system_call_op_q),
    .overflow_q(overflow_q), .store_valid_q(store_valid_q),
    .store_dword_q(store_dword_q), .store_addr_q(store_addr_q),
    .store_data_q(store_data_q), .tlb_cmd_q(tlb_cmd_q),
    .issue_alone_q(issue_alone_q), .stall_q(stall_q)
  );

  // Clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Compare tasks, one per result kind
  task automatic check_bit(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_word(input string n, input logic [63:0] e,
                            input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_cmd(input string n, input logic [3:0] e,
                           input logic [3:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // One issue cycle, outputs settled on return
  task automatic issue(input int_exec_pkg::op_type o, input logic [63:0] a,
                       input logic [63:0] b, input logic [15:0] im);
    @(posedge clk);
    issue_valid <= 1'b1;
    op <= o;
    source_reg_a <= a;
    source_reg_b <= b;
    imm <= im;
    @(posedge clk);
    issue_valid <= 1'b0;
    #1;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    tally_and_finish;
  end

  // Main sequence
  initial begin
    rows[0] = '{int_exec_pkg::OP_SHIFT_LEFT, Z, 64'h40000001, 16'h0, 5'h1,
                1'b0, 64'hFFFFFFFF80000002};
    rows[1] = '{int_exec_pkg::OP_SHIFT_LEFT_VAR, 64'hFF00000000000023,
                64'h1, 16'h0, 5'h0, 1'b0, 64'h8};
    rows[2] = '{int_exec_pkg::OP_SHIFT_RZERO, Z, 64'h80000000, 16'h0,
                5'h4, 1'b0, 64'h08000000};
    rows[3] = '{int_exec_pkg::OP_SHIFT_RZERO_VAR, 64'h3F, 64'hFFFFFFFF,
                16'h0, 5'h0, 1'b0, 64'h1};
    rows[4] = '{int_exec_pkg::OP_SHIFT_RSIGN, Z, 64'h80000000, 16'h0,
                5'h4, 1'b0, 64'hFFFFFFFFF8000000};
    rows[5] = '{int_exec_pkg::OP_SHIFT_RSIGN_VAR, 64'h1F, 64'h80000000,
                16'h0, 5'h0, 1'b0, M};
    rows[6] = '{int_exec_pkg::OP_LESS_SET, M, Z, 16'h0, 5'h0, 1'b0, 64'h1};
    rows[7] = '{int_exec_pkg::OP_LESS_SET, Z, M, 16'h0, 5'h0, 1'b0, Z};
    rows[8] = '{int_exec_pkg::OP_LESS_SET_IMM, M - 64'h1, Z, 16'hFFFF,
                5'h0, 1'b0, 64'h1};
    rows[9] = '{int_exec_pkg::OP_LESS_SET_U, M, Z, 16'h0, 5'h0, 1'b0, Z};
    rows[10] = '{int_exec_pkg::OP_LESS_SET_IMM_U, 64'h5, Z, 16'hFFFF,
                 5'h0, 1'b0, 64'h1};
    rows[11] = '{int_exec_pkg::OP_XOR_REG, 64'hF0F0, 64'hFF00, 16'h0,
                 5'h0, 1'b0, 64'h0FF0};
    rows[12] = '{int_exec_pkg::OP_XOR_IMM, Z, Z, 16'h8001, 5'h0, 1'b0,
                 64'h8001};
    rows[13] = '{int_exec_pkg::OP_SUBTRACT_NO_OVF, 64'h80000000, 64'h1,
                 16'h0, 5'h0, 1'b0, 64'h7FFFFFFF};
    rows[14] = '{int_exec_pkg::OP_SUBTRACT, 64'h5, 64'h7, 16'h0, 5'h0,
                 1'b0, M - 64'h1};
    rows[15] = '{int_exec_pkg::OP_TRAP_EQ, 64'h5, 64'h5, 16'h0, 5'h0,
                 1'b1, 64'h1};
    rows[16] = '{int_exec_pkg::OP_TRAP_EQ_IMM, M, Z, 16'hFFFF, 5'h0,
                 1'b1, 64'h1};
    rows[17] = '{int_exec_pkg::OP_TRAP_NE, 64'h5, 64'h5, 16'h0, 5'h0,
                 1'b1, Z};
    rows[18] = '{int_exec_pkg::OP_TRAP_GE, M, Z, 16'h0, 5'h0, 1'b1, Z};
    rows[19] = '{int_exec_pkg::OP_TRAP_GE_IMM, Z, Z, 16'hFFFF, 5'h0,
                 1'b1, 64'h1};
    rows[20] = '{int_exec_pkg::OP_TRAP_LT, M, Z, 16'h0, 5'h0, 1'b1, 64'h1};
    rows[21] = '{int_exec_pkg::OP_TRAP_GE_U, M, Z, 16'h0, 5'h0, 1'b1, 64'h1};
    rows[22] = '{int_exec_pkg::OP_TRAP_GE_IMM_U, Z, Z, 16'hFFFF, 5'h0,
                 1'b1, Z};
    rows[23] = '{int_exec_pkg::OP_TRAP_LT_IMM_U, 64'h5, Z, 16'hFFFF, 5'h0,
                 1'b1, 64'h1};
    rows[24] = '{int_exec_pkg::OP_TRAP_LT_U, 64'h5, M, 16'h0, 5'h0, 1'b1,
                 64'h1};
    rows[25] = '{int_exec_pkg::OP_TRAP_NE_IMM, M, Z, 16'hFFFF, 5'h0, 1'b1,
                 Z};
    rows[26] = '{int_exec_pkg::OP_TRAP_LT_IMM, M, Z, 16'h0, 5'h0, 1'b1,
                 64'h1};
    sys_rst = 1'b1;
    issue_valid = 1'b0;
    op = int_exec_pkg::OP_ISSUE_ALONE_NOP;
    source_reg_a = Z;
    source_reg_b = Z;
    imm = 16'h0;
    shift_amount_field = 5'h0;
    coproc_reg = 64'h1122334455667788;
    irq_pending = 1'b0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    check_word("result_q", Z, result_q);
    check_bit("stall_q", 1'b0, stall_q);
    check_cmd("tlb_cmd_q", 4'h0, tlb_cmd_q);
    // Table of ordinary operations
    for (int i = 0; i < ROWS; i++) begin
      shift_amount_field <= rows[i].sh;
      issue(rows[i].op, rows[i].a, rows[i].b, rows[i].im);
      check_bit("trap_q", rows[i].trap & rows[i].exp[0], trap_q);
      check_bit("result_valid_q", ~rows[i].trap, result_valid_q);
      if (!rows[i].trap) begin
        check_word("result_q", rows[i].exp, result_q);
      end
    end
    // Back-to-back issues
    @(posedge clk);
    issue_valid <= 1'b1;
    op <= int_exec_pkg::OP_XOR_REG;
    source_reg_a <= 64'hF;
    source_reg_b <= 64'h3;
    @(posedge clk);
    op <= int_exec_pkg::OP_LESS_SET_U;
    source_reg_a <= 64'h1;
    source_reg_b <= 64'h2;
    #1;
    check_word("result_q", 64'hC, result_q);
    @(posedge clk);
    issue_valid <= 1'b0;
    #1;
    check_word("result_q", 64'h1, result_q);
    // Exceptions without writeback
    issue(int_exec_pkg::OP_SYSTEM_CALL, Z, Z, 16'h0);
    check_bit("system_call_op_q", 1'b1, system_call_op_q);
    check_bit("result_valid_q", 1'b0, result_valid_q);
    issue(int_exec_pkg::OP_SUBTRACT, 64'h80000000, 64'h1, 16'h0);
    check_bit("overflow_q", 1'b1, overflow_q);
    check_bit("result_valid_q", 1'b0, result_valid_q);
    // Coprocessor stores
    issue(int_exec_pkg::OP_COP2_DSTORE, 64'h1000, Z, 16'hFFF8);
    check_bit("store_valid_q", 1'b1, store_valid_q);
    check_bit("store_dword_q", 1'b1, store_dword_q);
    check_word("store_addr_q", 64'hFF8, store_addr_q);
    check_word("store_data_q", coproc_reg, store_data_q);
    issue(int_exec_pkg::OP_COP2_WSTORE, 64'h2000, Z, 16'h0010);
    check_bit("store_dword_q", 1'b0, store_dword_q);
    check_word("store_addr_q", 64'h2010, store_addr_q);
    check_word("store_data_q", 64'h55667788, store_data_q);
    // Memory-management commands, one-hot each
    issue(int_exec_pkg::OP_TLB_WRITE_IDX, Z, Z, 16'h0);
    check_cmd("tlb_cmd_q", 4'h1 << int_exec_pkg::TLB_WRITE_IDX_BIT,
              tlb_cmd_q);
    issue(int_exec_pkg::OP_TLB_WRITE_RND, Z, Z, 16'h0);
    check_cmd("tlb_cmd_q", 4'h1 << int_exec_pkg::TLB_WRITE_RND_BIT,
              tlb_cmd_q);
    issue(int_exec_pkg::OP_TLB_PROBE, Z, Z, 16'h0);
    check_cmd("tlb_cmd_q", 4'h1 << int_exec_pkg::TLB_PROBE_BIT,
              tlb_cmd_q);
    issue(int_exec_pkg::OP_TLB_READ_IDX, Z, Z, 16'h0);
    check_cmd("tlb_cmd_q", 4'h1 << int_exec_pkg::TLB_READ_IDX_BIT,
              tlb_cmd_q);
    issue(int_exec_pkg::OP_ISSUE_ALONE_NOP, Z, Z, 16'h0);
    check_bit("issue_alone_q", 1'b1, issue_alone_q);
    check_bit("result_valid_q", 1'b0, result_valid_q);
    // Wait stalls, ignores issues, resumes on interrupt
    issue(int_exec_pkg::OP_WAIT_IRQ, Z, Z, 16'h0);
    check_bit("stall_q", 1'b1, stall_q);
    issue(int_exec_pkg::OP_LESS_SET, M, Z, 16'h0);
    check_bit("result_valid_q", 1'b0, result_valid_q);
    check_bit("stall_q", 1'b1, stall_q);
    @(posedge clk);
    irq_pending <= 1'b1;
    @(posedge clk);
    #1;
    check_bit("stall_q", 1'b0, stall_q);
    issue(int_exec_pkg::OP_WAIT_IRQ, Z, Z, 16'h0);
    check_bit("stall_q", 1'b0, stall_q);
    // Mid-run reset clears a stall and the held result
    @(posedge clk);
    irq_pending <= 1'b0;
    issue(int_exec_pkg::OP_WAIT_IRQ, Z, Z, 16'h0);
    check_bit("stall_q", 1'b1, stall_q);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    check_bit("stall_q", 1'b0, stall_q);
    check_word("result_q", Z, result_q);
    issue(int_exec_pkg::OP_LESS_SET, M, Z, 16'h0);
    check_word("result_q", 64'h1, result_q);
    tally_and_finish;
  end
endmodule
